// [rtl/cmi_consts.svh]
`ifndef CMI_CONSTS_SVH
`define CMI_CONSTS_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define CMI_OFF_INSTR 8'h00
`define CMI_OFF_STATUS 8'h04
`define CMI_OFF_REGWIN 8'h08
`define CMI_OFF_PTR 8'h0C

// ----------------------------------------
// instruction word fields
// ----------------------------------------
`define CMI_F_OP_LO 0
`define CMI_F_OP_HI 4
`define CMI_F_RD_LO 8
`define CMI_F_RD_HI 12
`define CMI_F_IO_LO 16
`define CMI_F_IO_HI 21
`define CMI_F_BIT_LO 24
`define CMI_F_BIT_HI 26
`define CMI_F_EXTRA 28
`define CMI_F_EXTRAM 29

// ----------------------------------------
// register window and pointer fields
// ----------------------------------------
`define CMI_W_SEL_LO 0
`define CMI_W_SEL_HI 4
`define CMI_W_DAT_LO 8
`define CMI_W_DAT_HI 15
`define CMI_W_WE 16
`define CMI_P_SP_LO 8
`define CMI_P_SP_HI 15
`define CMI_ST_BUSY 8

// ----------------------------------------
// status flag positions and reset values
// ----------------------------------------
`define CMI_FLG_C 0
`define CMI_FLG_Z 1
`define CMI_FLG_N 2
`define CMI_FLG_V 3
`define CMI_FLG_S 4
`define CMI_FLG_H 5
`define CMI_FLG_T 6
`define CMI_FLG_I 7
`define CMI_FLAGS_RST 8'h00
`define CMI_PTR_RST 8'h00
`define CMI_SP_RST 8'hFF

// ----------------------------------------
// cycle counts
// ----------------------------------------
`define CMI_CYC_ONE 4'h1
`define CMI_CYC_TWO 4'h2
`define CMI_CYC_EXTRA 4'h1

`endif

// [rtl/cmi_pkg.sv]
`default_nettype none
package cmi_pkg;

    typedef enum logic [4:0] {
        OP_IO_READ = 5'h00,
        OP_IO_WRITE = 5'h01,
        OP_PUSH = 5'h02,
        OP_POP = 5'h03,
        OP_MEMORY_SWAP = 5'h04,
        OP_LOAD_AND_SET_MEMORY = 5'h05,
        OP_LOAD_AND_CLEAR_MEMORY = 5'h06,
        OP_LOAD_AND_TOGGLE_MEMORY = 5'h07,
        OP_LOGICAL_LEFT_SHIFT = 5'h08,
        OP_LOGICAL_RIGHT_SHIFT = 5'h09,
        OP_ROTATE_LEFT_CARRY = 5'h0A,
        OP_ROTATE_RIGHT_CARRY = 5'h0B,
        OP_ARITHMETIC_RIGHT_SHIFT = 5'h0C,
        OP_NIBBLE_SWAP = 5'h0D,
        OP_GENERIC_FLAG_SET = 5'h0E,
        OP_GENERIC_FLAG_CLEAR = 5'h0F,
        OP_IO_BIT_SET = 5'h10,
        OP_IO_BIT_CLEAR = 5'h11,
        OP_BIT_TO_TRANSFER_FLAG = 5'h12,
        OP_TRANSFER_FLAG_TO_BIT = 5'h13,
        OP_BREAK = 5'h14,
        OP_IDLE_OP = 5'h15,
        OP_SLEEP = 5'h16,
        OP_WATCHDOG_RESTART = 5'h17
    } cmi_op_t;

    typedef struct packed {
        logic ext_ram;
        logic extra;
        logic [2:0] bsel;
        logic [5:0] io;
        logic [4:0] rd;
        cmi_op_t op;
    } cmi_instr_t;

    typedef enum logic {ST_IDLE, ST_EXEC} cmi_state_t;

endpackage

`default_nettype wire

// [rtl/cmi_exec.sv]
// The address map and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "cmi_consts.svh"

module cmi_exec #(
    parameter int RAM_AW = 8,
    parameter logic [3:0] EXT_WAIT = 4'h2
) (
    input wire logic hclk, // 25 MHz bus clock
    input wire logic hresetn, // async reset, active low
    input wire logic hsel, // slave select
    input wire logic [7:0] haddr, // byte address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write strobe
    input wire logic [2:0] hsize, // word only
    input wire logic [31:0] hwdata, // write data
    input wire logic hready, // bus ready
    output logic hreadyout, // always ready
    output logic hresp, // always okay
    output logic [31:0] hrdata, // read data
    output logic break_o, // break executed
    output logic sleep_o, // sleep executed
    output logic wdog_restart_o // watchdog restart executed
);

    // ----------------------------------------
    // storage
    // ----------------------------------------
    logic [7:0] rf [32];
    logic [7:0] io_mem [64];
    logic [7:0] ram [2**RAM_AW];
    logic [7:0] flags_q, flags_d;
    logic [RAM_AW-1:0] z_q, sp_q, sp_d;
    cmi_pkg::cmi_instr_t ins_q;
    cmi_pkg::cmi_state_t state_q;
    logic [3:0] cnt_q;
    logic [4:0] wsel_q;

    // ----------------------------------------
    // bus slave
    // ----------------------------------------
    logic wr_ph_q;
    logic [7:0] wr_addr_q;
    wire addr_ok = hsel && htrans[1] && hready;
    wire wr_take = wr_ph_q;
    wire [31:0] wdat = hwdata;
    wire start = wr_take && wr_addr_q == `CMI_OFF_INSTR && state_q == cmi_pkg::ST_IDLE;
    wire win_we = wr_take && wr_addr_q == `CMI_OFF_REGWIN && wdat[`CMI_W_WE];
    wire ptr_we = wr_take && wr_addr_q == `CMI_OFF_PTR;
    wire busy = state_q == cmi_pkg::ST_EXEC;
    wire fire = busy && cnt_q == 4'h0;

    cmi_pkg::cmi_instr_t new_ins;
    assign new_ins.op = cmi_pkg::cmi_op_t'(wdat[`CMI_F_OP_HI:`CMI_F_OP_LO]);
    assign new_ins.rd = wdat[`CMI_F_RD_HI:`CMI_F_RD_LO];
    assign new_ins.io = wdat[`CMI_F_IO_HI:`CMI_F_IO_LO];
    assign new_ins.bsel = wdat[`CMI_F_BIT_HI:`CMI_F_BIT_LO];
    assign new_ins.extra = wdat[`CMI_F_EXTRA];
    assign new_ins.ext_ram = wdat[`CMI_F_EXTRAM];

    wire [31:0] rd_mux =
        (haddr == `CMI_OFF_INSTR) ? 32'({2'h0, ins_q.ext_ram, ins_q.extra, 1'b0, ins_q.bsel,
                                         2'h0, ins_q.io, 3'h0, ins_q.rd, 3'h0, ins_q.op}) :
        (haddr == `CMI_OFF_STATUS) ? 32'({busy, flags_q}) :
        (haddr == `CMI_OFF_REGWIN) ? 32'({rf[wsel_q], 3'h0, wsel_q}) :
        (haddr == `CMI_OFF_PTR) ? 32'({8'(sp_q), 8'(z_q)}) : 32'h0000_0000;

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ph_q <= 1'b0;
            wr_addr_q <= 8'h00;
            hrdata <= 32'h0000_0000;
        end else begin
            wr_ph_q <= addr_ok && hwrite;
            wr_addr_q <= haddr;
            if (addr_ok && !hwrite) begin
                hrdata <= rd_mux;
            end
        end
    end

    // ----------------------------------------
    // cycle budget per instruction
    // ----------------------------------------
    function automatic logic [3:0] cmi_cycles(input cmi_pkg::cmi_instr_t i);
        logic ram_op;
        logic [3:0] n;
        ram_op = i.op inside {cmi_pkg::OP_PUSH, cmi_pkg::OP_POP, cmi_pkg::OP_MEMORY_SWAP,
                              cmi_pkg::OP_LOAD_AND_SET_MEMORY,
                              cmi_pkg::OP_LOAD_AND_CLEAR_MEMORY,
                              cmi_pkg::OP_LOAD_AND_TOGGLE_MEMORY};
        n = (ram_op && i.op != cmi_pkg::OP_PUSH) ? `CMI_CYC_TWO : `CMI_CYC_ONE;
        // external ram adds its own wait to the base count, in place of the internal extra cycle
        if (ram_op && i.ext_ram) begin
            n = n + EXT_WAIT;
        end else if (ram_op && i.extra) begin
            n = n + `CMI_CYC_EXTRA;
        end
        return n - `CMI_CYC_ONE;
    endfunction

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= cmi_pkg::ST_IDLE;
            cnt_q <= 4'h0;
            ins_q <= '0;
        end else if (start) begin
            state_q <= cmi_pkg::ST_EXEC;
            cnt_q <= cmi_cycles(new_ins);
            ins_q <= new_ins;
        end else if (fire) begin
            state_q <= cmi_pkg::ST_IDLE;
        end else if (busy) begin
            cnt_q <= cnt_q - 4'h1;
        end
    end

    // ----------------------------------------
    // datapath
    // ----------------------------------------
    wire [7:0] r_val = rf[ins_q.rd];
    wire [7:0] io_val = io_mem[ins_q.io];
    wire [7:0] m_old = ram[z_q];
    wire [RAM_AW-1:0] sp_up = sp_q + RAM_AW'(1);
    wire [7:0] bmask = 8'h01 << ins_q.bsel;
    wire cin = flags_q[`CMI_FLG_C];

    logic rf_we, io_we, ram_we;
    logic [7:0] rf_wd, io_wd, ram_wd, sh;
    logic [RAM_AW-1:0] ram_wa;
    logic sh_c, sh_on;

    always_comb begin
        rf_we = 1'b0;
        io_we = 1'b0;
        ram_we = 1'b0;
        rf_wd = r_val;
        io_wd = io_val;
        ram_wd = r_val;
        ram_wa = z_q;
        sp_d = sp_q;
        flags_d = flags_q;
        sh = r_val;
        sh_c = cin;
        sh_on = 1'b0;
        unique case (ins_q.op)
            cmi_pkg::OP_IO_READ: begin
                rf_we = 1'b1;
                rf_wd = io_val;
            end
            cmi_pkg::OP_IO_WRITE: begin
                io_we = 1'b1;
                io_wd = r_val;
            end
            cmi_pkg::OP_PUSH: begin
                ram_we = 1'b1;
                ram_wa = sp_q;
                sp_d = sp_q - RAM_AW'(1);
            end
            cmi_pkg::OP_POP: begin
                rf_we = 1'b1;
                rf_wd = ram[sp_up];
                sp_d = sp_up;
            end
            cmi_pkg::OP_MEMORY_SWAP, cmi_pkg::OP_LOAD_AND_SET_MEMORY,
            cmi_pkg::OP_LOAD_AND_CLEAR_MEMORY, cmi_pkg::OP_LOAD_AND_TOGGLE_MEMORY: begin
                rf_we = 1'b1;
                rf_wd = m_old;
                ram_we = 1'b1;
                unique case (ins_q.op)
                    cmi_pkg::OP_LOAD_AND_SET_MEMORY: ram_wd = r_val | m_old;
                    cmi_pkg::OP_LOAD_AND_CLEAR_MEMORY: ram_wd = ~r_val & m_old;
                    cmi_pkg::OP_LOAD_AND_TOGGLE_MEMORY: ram_wd = r_val ^ m_old;
                    default: ram_wd = r_val;
                endcase
            end
            cmi_pkg::OP_LOGICAL_LEFT_SHIFT, cmi_pkg::OP_ROTATE_LEFT_CARRY: begin
                sh_on = 1'b1;
                sh = {r_val[6:0], ins_q.op == cmi_pkg::OP_ROTATE_LEFT_CARRY && cin};
                sh_c = r_val[7];
                flags_d[`CMI_FLG_H] = r_val[3];
            end
            cmi_pkg::OP_LOGICAL_RIGHT_SHIFT, cmi_pkg::OP_ROTATE_RIGHT_CARRY,
            cmi_pkg::OP_ARITHMETIC_RIGHT_SHIFT: begin
                sh_on = 1'b1;
                sh_c = r_val[0];
                unique case (ins_q.op)
                    cmi_pkg::OP_ROTATE_RIGHT_CARRY: sh = {cin, r_val[7:1]};
                    cmi_pkg::OP_ARITHMETIC_RIGHT_SHIFT: sh = {r_val[7], r_val[7:1]};
                    default: sh = {1'b0, r_val[7:1]};
                endcase
            end
            cmi_pkg::OP_NIBBLE_SWAP: begin
                rf_we = 1'b1;
                rf_wd = {r_val[3:0], r_val[7:4]};
            end
            cmi_pkg::OP_GENERIC_FLAG_SET: flags_d[ins_q.bsel] = 1'b1;
            cmi_pkg::OP_GENERIC_FLAG_CLEAR: flags_d[ins_q.bsel] = 1'b0;
            cmi_pkg::OP_IO_BIT_SET: begin
                io_we = 1'b1;
                io_wd = io_val | bmask;
            end
            cmi_pkg::OP_IO_BIT_CLEAR: begin
                io_we = 1'b1;
                io_wd = io_val & ~bmask;
            end
            cmi_pkg::OP_BIT_TO_TRANSFER_FLAG: flags_d[`CMI_FLG_T] = r_val[ins_q.bsel];
            cmi_pkg::OP_TRANSFER_FLAG_TO_BIT: begin
                rf_we = 1'b1;
                rf_wd = (r_val & ~bmask) | (flags_q[`CMI_FLG_T] ? bmask : 8'h00);
            end
            default: ; // break, idle, sleep, watchdog: flags untouched
        endcase
        if (sh_on) begin
            rf_we = 1'b1;
            rf_wd = sh;
            flags_d[`CMI_FLG_C] = sh_c;
            flags_d[`CMI_FLG_Z] = sh == 8'h00;
            flags_d[`CMI_FLG_N] = sh[7];
            flags_d[`CMI_FLG_V] = sh[7] ^ sh_c;
        end
    end

    // arrays carry no reset; software initialises them through the window and instructions
    always_ff @(posedge hclk) begin
        if (fire && rf_we) begin
            rf[ins_q.rd] <= rf_wd;
        end else if (win_we) begin
            rf[wdat[`CMI_W_SEL_HI:`CMI_W_SEL_LO]] <= wdat[`CMI_W_DAT_HI:`CMI_W_DAT_LO];
        end
        if (fire && io_we) begin
            io_mem[ins_q.io] <= io_wd;
        end
        if (fire && ram_we) begin
            ram[ram_wa] <= ram_wd;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flags_q <= `CMI_FLAGS_RST;
            z_q <= RAM_AW'(`CMI_PTR_RST);
            sp_q <= RAM_AW'(`CMI_SP_RST);
            wsel_q <= 5'h00;
            break_o <= 1'b0;
            sleep_o <= 1'b0;
            wdog_restart_o <= 1'b0;
        end else begin
            if (fire) begin
                flags_q <= flags_d;
                sp_q <= sp_d;
            end else if (ptr_we) begin
                z_q <= RAM_AW'(wdat[7:0]);
                sp_q <= RAM_AW'(wdat[`CMI_P_SP_HI:`CMI_P_SP_LO]);
            end
            if (wr_take && wr_addr_q == `CMI_OFF_REGWIN) begin
                wsel_q <= wdat[`CMI_W_SEL_HI:`CMI_W_SEL_LO];
            end
            break_o <= fire && ins_q.op == cmi_pkg::OP_BREAK;
            sleep_o <= fire && ins_q.op == cmi_pkg::OP_SLEEP;
            wdog_restart_o <= fire && ins_q.op == cmi_pkg::OP_WATCHDOG_RESTART;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    wire plain = !new_ins.extra && !new_ins.ext_ram;

    a_io_one_cycle: assert property (
        start && new_ins.op inside {cmi_pkg::OP_IO_READ, cmi_pkg::OP_IO_WRITE}
        |=> fire ##1 (!busy && $stable(flags_q)))
        else $error("io transfer not one cycle or flags moved");
    a_push_stack: assert property (
        fire && ins_q.op == cmi_pkg::OP_PUSH
        |=> sp_q == $past(sp_q) - RAM_AW'(1) && flags_q == $past(flags_q))
        else $error("push did not move stack");
    a_pop_two: assert property (
        start && new_ins.op == cmi_pkg::OP_POP && plain |=> !fire ##1 fire ##1 !busy)
        else $error("pop not two cycles");
    a_atomic_ret: assert property (
        fire && ins_q.op == cmi_pkg::OP_LOAD_AND_SET_MEMORY
        |=> rf[ins_q.rd] == $past(m_old) && ram[z_q] == ($past(m_old) | $past(r_val)))
        else $error("load-set result wrong");
    a_clear_mem: assert property (
        fire && ins_q.op == cmi_pkg::OP_LOAD_AND_CLEAR_MEMORY
        |=> ram[z_q] == ($past(m_old) & ~$past(r_val)))
        else $error("load-clear result wrong");
    a_extra_cycle: assert property (
        start && new_ins.op == cmi_pkg::OP_MEMORY_SWAP && new_ins.extra && !new_ins.ext_ram
        |=> !fire [*2] ##1 fire)
        else $error("extra sram cycle missing");
    a_shift_carry: assert property (
        fire && ins_q.op == cmi_pkg::OP_LOGICAL_LEFT_SHIFT
        |=> flags_q[`CMI_FLG_C] == $past(r_val[7]) && rf[ins_q.rd] == {$past(r_val[6:0]), 1'b0})
        else $error("left shift wrong");
    a_asr_keep: assert property (
        fire && ins_q.op == cmi_pkg::OP_ARITHMETIC_RIGHT_SHIFT
        |=> rf[ins_q.rd][7] == $past(r_val[7]) && flags_q[`CMI_FLG_C] == $past(r_val[0]))
        else $error("arith shift wrong");
    a_shift_ovf: assert property (
        fire && sh_on |=> flags_q[`CMI_FLG_V] == (flags_q[`CMI_FLG_N] ^ flags_q[`CMI_FLG_C]))
        else $error("overflow not N xor C");
    a_flag_set: assert property (
        fire && ins_q.op == cmi_pkg::OP_GENERIC_FLAG_SET |=> flags_q[ins_q.bsel])
        else $error("flag not set");
    a_flag_clear: assert property (
        fire && ins_q.op == cmi_pkg::OP_GENERIC_FLAG_CLEAR |=> !flags_q[ins_q.bsel])
        else $error("flag not cleared");
    a_ctl_pulse: assert property (
        break_o |-> !sleep_o && !wdog_restart_o ##1 !break_o)
        else $error("control pulse too long");

    c_pop_done: cover property (fire && ins_q.op == cmi_pkg::OP_POP);
    c_ext_ram: cover property (fire && ins_q.ext_ram && ins_q.op == cmi_pkg::OP_PUSH);
    c_rotate: cover property (fire && ins_q.op == cmi_pkg::OP_ROTATE_RIGHT_CARRY && cin);

endmodule

`default_nettype wire

// [verif/cmi_ahb_master.sv]
`timescale 1ns/1ps
`default_nettype none
module cmi_ahb_master (
    input wire logic hclk, // bus clock
    output logic hsel, // slave select
    output logic [7:0] haddr, // byte address
    output logic [1:0] htrans, // transfer type
    output logic hwrite, // write strobe
    output logic [2:0] hsize, // always word
    output logic [31:0] hwdata, // write data
    input wire logic hready, // bus ready
    input wire logic [31:0] hrdata, // read data
    output logic stuck // a wait ran out
);
    initial begin
        hsel = 1'b0;
        haddr = 8'h00;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
        stuck = 1'b0;
    end

    // ----------------------------------------
    // bus cycles
    // ----------------------------------------
    // bounded: a slave that never answers marks stuck instead of hanging
    task automatic wait_ready();
        int n;
        n = 0;
        @(posedge hclk);
        while (hready !== 1'b1 && n < 64) begin
            n++;
            @(posedge hclk);
        end
        if (hready !== 1'b1) stuck = 1'b1;
    endtask

    // entered just after a rising edge; read data taken at the data-phase edge
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                        output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask
endmodule
`default_nettype wire

// [verif/cmi_exec_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module cmi_exec_bench;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel, hwrite, hready, hresp, stuck, break_o, sleep_o, wdog_restart_o;
    logic [7:0] haddr, ram_m, fl, av;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, rv, v;
    logic [15:0] e;
    int errors = 0;
    int total_checks = 0;
    int brk_n = 0;
    int slp_n = 0;
    int wdg_n = 0;

    always #20 hclk = ~hclk;

    cmi_ahb_master cmi_ahb_master_inst (.hclk(hclk), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .stuck(stuck));
    cmi_exec cmi_exec_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .break_o(break_o),
        .sleep_o(sleep_o), .wdog_restart_o(wdog_restart_o));

    // a stuck level would count once per cycle, so a count of one means one pulse
    always @(posedge hclk) begin
        brk_n += (break_o === 1'b1);
        slp_n += (sleep_o === 1'b1);
        wdg_n += (wdog_restart_o === 1'b1);
    end

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic report_and_stop();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        cmi_ahb_master_inst.xfer(1'b1, a, d, rv);
    endtask

    task automatic rd(input logic [7:0] a);
        cmi_ahb_master_inst.xfer(1'b0, a, 32'h0000_0000, rv);
    endtask

    task automatic wait_idle();
        int n;
        for (n = 0; n < 20; n++) begin
            rd(8'h04);
            if (rv[8] === 1'b0) break;
        end
        if (rv[8] !== 1'b0) begin
            errors++;
            report_and_stop();
        end
    endtask

    task automatic run(input logic [31:0] w);
        wr(8'h00, w);
        wait_idle();
    endtask

    task automatic set_reg(input logic [4:0] n, input logic [7:0] d);
        wr(8'h08, {15'h0000, 1'b1, d, 3'h0, n});
    endtask

    task automatic get_reg(input logic [4:0] n);
        wr(8'h08, {27'h0000000, n});
        rd(8'h08);
        v = {24'h000000, rv[15:8]};
    endtask

    task automatic check_flags();
        rd(8'h04);
        check(rv, {24'h000000, fl});
    endtask

    // mk[0] extra-cycle mark, mk[1] external ram
    function automatic logic [31:0] ins(input logic [4:0] op, input logic [4:0] r,
                                        input logic [5:0] io, input logic [2:0] b,
                                        input logic [1:0] mk);
        return {2'h0, mk, 1'b0, b, 2'h0, io, 3'h0, r, 3'h0, op};
    endfunction

    function automatic logic [15:0] shm(input logic [4:0] op, input logic [7:0] x,
                                        input logic [7:0] f);
        logic [7:0] r;
        logic c;
        case (op)
            cmi_pkg::OP_LOGICAL_LEFT_SHIFT: {c, r} = {x, 1'b0};
            cmi_pkg::OP_ROTATE_LEFT_CARRY: {c, r} = {x, f[0]};
            cmi_pkg::OP_LOGICAL_RIGHT_SHIFT: {r, c} = {1'b0, x};
            cmi_pkg::OP_ROTATE_RIGHT_CARRY: {r, c} = {f[0], x};
            default: {r, c} = {x[7], x};
        endcase
        f[0] = c;
        f[1] = (r == 8'h00);
        f[2] = r[7];
        f[3] = r[7] ^ c;
        if (op == cmi_pkg::OP_LOGICAL_LEFT_SHIFT || op == cmi_pkg::OP_ROTATE_LEFT_CARRY) begin
            f[5] = x[3];
        end
        return {f, r};
    endfunction

    initial begin
        #2ms;
        errors++;
        report_and_stop();
    end

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        fl = 8'h00;
        check_flags();
        rd(8'h0C);
        check(rv, 32'h0000FF00);
        rd(8'h10);
        check(rv, 32'h00000000);
        set_reg(5'h01, 8'hA5);
        run(ins(cmi_pkg::OP_IO_WRITE, 5'h01, 6'h05, 3'h0, 2'h0));
        run(ins(cmi_pkg::OP_IO_READ, 5'h03, 6'h05, 3'h0, 2'h0));
        get_reg(5'h03);
        check(v, 32'h000000A5);
        run(ins(cmi_pkg::OP_IO_BIT_SET, 5'h00, 6'h05, 3'h1, 2'h0));
        run(ins(cmi_pkg::OP_IO_BIT_CLEAR, 5'h00, 6'h05, 3'h0, 2'h0));
        run(ins(cmi_pkg::OP_IO_READ, 5'h02, 6'h05, 3'h0, 2'h0));
        get_reg(5'h02);
        check(v, 32'h000000A6);
        check_flags();
        run(ins(cmi_pkg::OP_PUSH, 5'h01, 6'h00, 3'h0, 2'h0));
        rd(8'h0C);
        check(rv, 32'h0000FE00);
        run(ins(cmi_pkg::OP_POP, 5'h04, 6'h00, 3'h0, 2'h1));
        get_reg(5'h04);
        check(v, 32'h000000A5);
        rd(8'h00);
        check(rv, ins(cmi_pkg::OP_POP, 5'h04, 6'h00, 3'h0, 2'h1));
        run(ins(cmi_pkg::OP_PUSH, 5'h02, 6'h00, 3'h0, 2'h0));
        run(ins(cmi_pkg::OP_POP, 5'h07, 6'h00, 3'h0, 2'h0));
        get_reg(5'h07);
        check(v, 32'h000000A6);
        rd(8'h0C);
        check(rv, 32'h0000FF00);
        check_flags();
        wr(8'h0C, 32'h0000FF10);
        for (int i = 0; i < 5; i++) begin
            av = (i == 0) ? 8'h3C : (i == 1) ? 8'h0F : (i == 2) ? 8'h30 : (i == 3) ? 8'hFF : 8'h00;
            set_reg(5'h06, av);
            run(ins(5'(cmi_pkg::OP_MEMORY_SWAP + i % 4), 5'h06, 6'h00, 3'h0,
                    (i == 2) ? 2'h2 : (i == 0) ? 2'h1 : 2'h0));
            get_reg(5'h06);
            if (i > 0) check(v, {24'h000000, ram_m});
            ram_m = (i == 1) ? (av | ram_m) : (i == 2) ? (~av & ram_m) :
                    (i == 3) ? (av ^ ram_m) : av;
        end
        check_flags();
        // second instruction lands while the slow external swap is still busy
        set_reg(5'h09, 8'h11);
        set_reg(5'h06, 8'h55);
        wr(8'h00, ins(cmi_pkg::OP_MEMORY_SWAP, 5'h06, 6'h00, 3'h0, 2'h2));
        wr(8'h00, ins(cmi_pkg::OP_IO_READ, 5'h09, 6'h05, 3'h0, 2'h0));
        wait_idle();
        get_reg(5'h09);
        check(v, 32'h00000011);
        get_reg(5'h06);
        check(v, {24'h000000, ram_m});
        for (int i = 0; i < 8; i++) begin
            run(ins(cmi_pkg::OP_GENERIC_FLAG_SET, 5'h00, 6'h00, 3'(i), 2'h0));
            fl[i] = 1'b1;
            check_flags();
        end
        for (int i = 0; i < 8; i += 2) begin
            run(ins(cmi_pkg::OP_GENERIC_FLAG_CLEAR, 5'h00, 6'h00, 3'(i), 2'h0));
            fl[i] = 1'b0;
            check_flags();
        end
        for (int k = 0; k < 3; k++) begin
            for (int j = 0; j < 5; j++) begin
                av = (k == 0) ? 8'h81 : (k == 1) ? 8'h46 : 8'h01;
                set_reg(5'h0A, av);
                run(ins(5'(cmi_pkg::OP_LOGICAL_LEFT_SHIFT + j), 5'h0A, 6'h00, 3'h0, 2'h0));
                e = shm(5'(cmi_pkg::OP_LOGICAL_LEFT_SHIFT + j), av, fl);
                fl = e[15:8];
                get_reg(5'h0A);
                check(v, {24'h000000, e[7:0]});
                check_flags();
            end
        end
        set_reg(5'h0B, 8'h3C);
        run(ins(cmi_pkg::OP_NIBBLE_SWAP, 5'h0B, 6'h00, 3'h0, 2'h0));
        get_reg(5'h0B);
        check(v, 32'h000000C3);
        check_flags();
        set_reg(5'h0C, 8'h08);
        set_reg(5'h0D, 8'h00);
        for (int i = 0; i < 2; i++) begin
            run(ins(cmi_pkg::OP_BIT_TO_TRANSFER_FLAG, 5'h0C, 6'h00, (i == 0) ? 3'h3 : 3'h2, 2'h0));
            fl[6] = (i == 0);
            check_flags();
            run(ins(cmi_pkg::OP_TRANSFER_FLAG_TO_BIT, 5'h0D, 6'h00, 3'h0, 2'h0));
            get_reg(5'h0D);
            check(v, (i == 0) ? 32'h00000001 : 32'h00000000);
            check_flags();
        end
        for (int i = 0; i < 4; i++) begin
            run(ins(5'(cmi_pkg::OP_BREAK + i), 5'h00, 6'h00, 3'h0, 2'h0));
            check_flags();
        end
        check({brk_n[7:0], slp_n[7:0], wdg_n[7:0]}, 32'h00010101);
        check({31'h00000000, stuck}, 32'h00000000);
        check({31'h00000000, hresp}, 32'h00000000);
        report_and_stop();
    end
endmodule
`default_nettype wire
